// ==== angc_pkg.sv ====
// Package: offsets, field layout and reset values of the next-page/config bank
package angc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] ANGC_OFS_NP_TX   = 5'h07;
  localparam logic [4:0] ANGC_OFS_NP_RX   = 5'h08;
  localparam logic [4:0] ANGC_OFS_GIG_CFG = 5'h09;
  localparam logic [4:0] ANGC_OFS_AN_EXP  = 5'h06;

  // ****************************************
  // Next-page word field positions
  // ****************************************
  localparam int ANGC_NP_MORE_BIT   = 15;
  localparam int ANGC_NP_ACK_BIT    = 14;
  localparam int ANGC_NP_MSG_BIT    = 13;
  localparam int ANGC_NP_COMPLY_BIT = 12;
  localparam int ANGC_NP_TOGGLE_BIT = 11;
  localparam int ANGC_NP_CODE_MSB   = 10;

  // ****************************************
  // Gigabit config word field positions
  // ****************************************
  localparam int ANGC_CFG_TEST_LSB   = 13;
  localparam int ANGC_CFG_MAN_MS_BIT = 12;
  localparam int ANGC_CFG_MS_VAL_BIT = 11;
  localparam int ANGC_CFG_PORT_BIT   = 10;
  localparam int ANGC_CFG_FD_BIT     = 9;
  localparam int ANGC_CFG_HD_BIT     = 8;
  localparam int ANGC_CFG_DIAG_BIT   = 7;

  // Expansion-status bits held by this bank
  localparam int ANGC_EXP_LOC_ABLE_BIT = 6;
  localparam int ANGC_EXP_LOC_8_BIT    = 5;
  localparam int ANGC_EXP_PAGE_RX_BIT  = 1;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [15:0] ANGC_NP_RESET      = 16'h2001;
  localparam logic [15:0] ANGC_NP_TX_WR_MASK = 16'hb7ff;
  // Bit 9 resets to one; the strap option overwrites it after release
  localparam logic [15:0] ANGC_CFG_RESET     = 16'h0300;
  localparam logic [15:0] ANGC_CFG_WR_MASK   = 16'hff80;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ANGC_TM_NORMAL,
    ANGC_TM_WAVEFORM,
    ANGC_TM_JITTER_MASTER,
    ANGC_TM_JITTER_SLAVE,
    ANGC_TM_DISTORTION,
    ANGC_TM_SCRAMBLED_IDLE,
    ANGC_TM_PATTERN_0001,
    ANGC_TM_PULSE_63_ZERO
  } angc_test_mode_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } angc_mgmt_req_type;

  typedef struct packed {
    logic        valid;
    logic        more;
    logic        ack;
    logic        msg;
    logic        comply;
    logic        toggle;
    logic [10:0] code;
  } angc_page_type;

  typedef struct packed {
    angc_test_mode_type test_mode;
    logic               manual_ms_en;
    logic               force_master;
    logic               adv_multi_port;
    logic               adv_gig_fd;
    logic               adv_gig_hd;
    logic               auto_cable_diag_on_link_loss;
  } angc_cfg_type;

endpackage : angc_pkg

// ==== angc_page_rx.sv ====
// Receive next-page capture and page-received flag
`timescale 1ns/100ps
module angc_page_rx (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  // Page from the negotiation logic
  input  wire angc_pkg::angc_page_type page_in,
  // Read of the expansion status clears the flag
  input  wire logic                   status_read_in,
  // Captured word and flag
  output logic [15:0]                 rx_word_out,
  output logic                        page_rx_out
);

  logic [15:0] rx_word_q;
  logic        page_rx_q;

  // Only a complete accepted page is stored; others leave the word alone
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_word_q <= angc_pkg::ANGC_NP_RESET;
    end else if (page_in.valid) begin
      rx_word_q <= {page_in.more, page_in.ack, page_in.msg,
                    page_in.comply, page_in.toggle, page_in.code};
    end
  end

  // Arrival wins over the read clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      page_rx_q <= 1'b0;
    end else if (page_in.valid) begin
      page_rx_q <= 1'b1;
    end else if (status_read_in) begin
      page_rx_q <= 1'b0;
    end
  end

  assign rx_word_out = rx_word_q;
  assign page_rx_out = page_rx_q;

endmodule : angc_page_rx

// ==== angc_cfg_reg.sv ====
// Gigabit configuration word storage
`timescale 1ns/100ps
module angc_cfg_reg (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // Full-duplex strap, sampled once after reset release
  input  wire logic         fd_strap_in,
  input  wire logic         strap_load_in,
  // Write port
  input  wire logic         wr_in,
  input  wire logic [15:0]  wdata_in,
  // Word
  output logic [15:0]       cfg_word_out
);

  logic [15:0] cfg_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q <= angc_pkg::ANGC_CFG_RESET;
    end else if (strap_load_in) begin
      cfg_q[angc_pkg::ANGC_CFG_FD_BIT] <= fd_strap_in;
    end else if (wr_in) begin
      // Reserved low bits stay zero
      cfg_q <= wdata_in & angc_pkg::ANGC_CFG_WR_MASK;
    end
  end

  assign cfg_word_out = cfg_q;

endmodule : angc_cfg_reg

// ==== angc_regs.sv ====
// Next-page and gigabit configuration register bank
`timescale 1ns/100ps
module angc_regs #(
  // Package option: 1 takes bit 9 from the strap, 0 resets it to one
  parameter bit FD_FROM_STRAP = 1'b0
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  // Management access (decoded serial frames, same clock)
  input  wire angc_pkg::angc_mgmt_req_type mgmt_req_in,
  output logic [15:0]                    mgmt_rdata_out,
  output logic                           mgmt_hit_out,
  // Strap pin
  input  wire logic                      fd_strap_pin_in,
  // Negotiation engine
  input  wire logic                      tx_ack_in,
  input  wire logic                      page_sent_in,
  input  wire angc_pkg::angc_page_type   rx_page_in,
  input  wire logic                      link_up_in,
  output logic [15:0]                    tx_word_out,
  output logic                           tx_msg_page_out,
  output logic [10:0]                    tx_code_out,
  // Configuration to the PMA and diagnostics
  output angc_pkg::angc_cfg_type         cfg_out,
  output logic                           ms_conflict_risk_out,
  output logic                           diag_start_out,
  output logic                           page_rx_out
);

  // ****************************************
  // Reset release and strap capture
  // ****************************************
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       strap_meta_q;
  logic       strap_sync_q;
  logic [1:0] strap_wait_q;
  logic       strap_load;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      strap_meta_q <= fd_strap_pin_in;
      strap_sync_q <= strap_meta_q;
    end
  end

  // Load happens once, after the strap synchroniser has filled
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != 2'h3) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end
  end

  assign strap_load = FD_FROM_STRAP && (strap_wait_q == 2'h2);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_tx;
  logic wr_cfg;
  logic rd_exp;

  assign wr_tx  = mgmt_req_in.wr && hit(mgmt_req_in.addr,
                  angc_pkg::ANGC_OFS_NP_TX);
  assign wr_cfg = mgmt_req_in.wr && hit(mgmt_req_in.addr,
                  angc_pkg::ANGC_OFS_GIG_CFG);
  assign rd_exp = mgmt_req_in.rd && hit(mgmt_req_in.addr,
                  angc_pkg::ANGC_OFS_AN_EXP);

  // ****************************************
  // Transmit next-page word
  // ****************************************
  logic [15:0] tx_q;
  logic        last_toggle_q;

  // Software owns only the writable fields
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tx_q <= angc_pkg::ANGC_NP_RESET;
    end else if (wr_tx) begin
      tx_q <= mgmt_req_in.wdata & angc_pkg::ANGC_NP_TX_WR_MASK;
    end
  end

  // Toggle tracks the last exchanged word; starts so first page sends 0
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      last_toggle_q <= 1'b1;
    end else if (page_sent_in) begin
      last_toggle_q <= ~last_toggle_q;
    end
  end

  logic [15:0] tx_word;
  always_comb begin
    tx_word = tx_q;
    tx_word[angc_pkg::ANGC_NP_ACK_BIT]    = tx_ack_in;
    tx_word[angc_pkg::ANGC_NP_TOGGLE_BIT] = ~last_toggle_q;
  end

  assign tx_word_out     = tx_word;
  assign tx_msg_page_out = tx_q[angc_pkg::ANGC_NP_MSG_BIT];
  assign tx_code_out     = tx_q[angc_pkg::ANGC_NP_CODE_MSB:0];

  // ****************************************
  // Receive word and gigabit config
  // ****************************************
  logic [15:0] rx_word;
  logic [15:0] cfg_word;
  logic        page_rx;

  // Partner word is never software-written; writes to it decode to nothing
  angc_page_rx u_page_rx (
    .clk_in         (clk_in),
    .rst_b_in       (rst_sync_q),
    .page_in        (rx_page_in),
    .status_read_in (rd_exp),
    .rx_word_out    (rx_word),
    .page_rx_out    (page_rx)
  );

  angc_cfg_reg u_cfg (
    .clk_in        (clk_in),
    .rst_b_in      (rst_sync_q),
    .fd_strap_in   (strap_sync_q),
    .strap_load_in (strap_load),
    .wr_in         (wr_cfg),
    .wdata_in      (mgmt_req_in.wdata),
    .cfg_word_out  (cfg_word)
  );

  always_comb begin
    cfg_out.test_mode = angc_pkg::angc_test_mode_type'(
      cfg_word[15:angc_pkg::ANGC_CFG_TEST_LSB]);
    cfg_out.manual_ms_en   = cfg_word[angc_pkg::ANGC_CFG_MAN_MS_BIT];
    cfg_out.force_master   = cfg_word[angc_pkg::ANGC_CFG_MAN_MS_BIT] &&
                             cfg_word[angc_pkg::ANGC_CFG_MS_VAL_BIT];
    cfg_out.adv_multi_port = cfg_word[angc_pkg::ANGC_CFG_PORT_BIT];
    cfg_out.adv_gig_fd     = cfg_word[angc_pkg::ANGC_CFG_FD_BIT];
    cfg_out.adv_gig_hd     = cfg_word[angc_pkg::ANGC_CFG_HD_BIT];
    cfg_out.auto_cable_diag_on_link_loss =
      cfg_word[angc_pkg::ANGC_CFG_DIAG_BIT];
  end

  // Manual role is honoured blindly; a clash with the partner can stop link
  assign ms_conflict_risk_out =
    cfg_word[angc_pkg::ANGC_CFG_MAN_MS_BIT];
  assign page_rx_out = page_rx;

  // ****************************************
  // Automatic diagnostic on link loss
  // ****************************************
  logic link_was_q;
  logic diag_q;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link_was_q <= 1'b0;
      diag_q     <= 1'b0;
    end else begin
      link_was_q <= link_up_in;
      diag_q     <= link_was_q && !link_up_in &&
                    cfg_word[angc_pkg::ANGC_CFG_DIAG_BIT];
    end
  end

  assign diag_start_out = diag_q;

  // ****************************************
  // Read data
  // ****************************************
  logic [15:0] exp_word;
  always_comb begin
    exp_word = 16'h0000;
    exp_word[angc_pkg::ANGC_EXP_LOC_ABLE_BIT] = 1'b1;
    exp_word[angc_pkg::ANGC_EXP_LOC_8_BIT]    = 1'b1;
    exp_word[angc_pkg::ANGC_EXP_PAGE_RX_BIT]  = page_rx;
  end

  logic [15:0] rdata_q;
  logic        hit_q;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 16'h0000;
      hit_q   <= 1'b0;
    end else begin
      hit_q <= mgmt_req_in.rd;
      case (mgmt_req_in.addr)
        angc_pkg::ANGC_OFS_NP_TX:   rdata_q <= tx_word;
        angc_pkg::ANGC_OFS_NP_RX:   rdata_q <= rx_word;
        angc_pkg::ANGC_OFS_GIG_CFG: rdata_q <= cfg_word;
        angc_pkg::ANGC_OFS_AN_EXP:  rdata_q <= exp_word;
        default:                    rdata_q <= 16'h0000;
      endcase
    end
  end

  assign mgmt_rdata_out = rdata_q;
  assign mgmt_hit_out   = hit_q;

endmodule : angc_regs

// ==== angc_regs_properties.sv ====
// Port-level checks for the next-page and gigabit config bank
`timescale 1ns/100ps
module angc_regs_properties #(
  parameter bit FD_FROM_STRAP = 1'b0
) (
  // Clock and reset
  input wire logic                        clk_in,
  input wire logic                        rst_b_in,
  // Bank ports
  input wire angc_pkg::angc_mgmt_req_type mgmt_req_in,
  input wire logic [15:0]                 mgmt_rdata_out,
  input wire logic                        mgmt_hit_out,
  input wire logic                        fd_strap_pin_in,
  input wire logic                        tx_ack_in,
  input wire logic                        page_sent_in,
  input wire angc_pkg::angc_page_type     rx_page_in,
  input wire logic                        link_up_in,
  input wire logic [15:0]                 tx_word_out,
  input wire logic                        tx_msg_page_out,
  input wire logic [10:0]                 tx_code_out,
  input wire angc_pkg::angc_cfg_type      cfg_out,
  input wire logic                        ms_conflict_risk_out,
  input wire logic                        diag_start_out,
  input wire logic                        page_rx_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ********
  // Assertions
  // ********
  read_hit_a: assert property (mgmt_req_in.rd |=> mgmt_hit_out)
    else $error("no hit after read");
  idle_hit_a: assert property (!mgmt_req_in.rd |=> !mgmt_hit_out)
    else $error("hit without read");
  ack_live_a: assert property (tx_word_out[14] == tx_ack_in)
    else $error("ack bit not live");
  toggle_flip_a: assert property (page_sent_in |=>
    tx_word_out[11] != $past(tx_word_out[11]))
    else $error("toggle did not flip");
  toggle_hold_a: assert property (!page_sent_in |=>
    $stable(tx_word_out[11]))
    else $error("toggle moved without page");
  page_flag_a: assert property (rx_page_in.valid |=> page_rx_out)
    else $error("page flag not set");
  reserved_zero_a: assert property (mgmt_req_in.rd &&
    mgmt_req_in.addr == angc_pkg::ANGC_OFS_GIG_CFG
    |=> mgmt_rdata_out[6:0] == 7'h00)
    else $error("reserved bits not zero");
  role_gate_a: assert property (cfg_out.force_master |->
    cfg_out.manual_ms_en)
    else $error("role forced while manual off");
  conflict_flag_a: assert property (ms_conflict_risk_out ==
    cfg_out.manual_ms_en)
    else $error("conflict flag wrong");
  diag_launch_a: assert property ($fell(link_up_in) |-> ##1
    diag_start_out == $past(cfg_out.auto_cable_diag_on_link_loss, 1))
    else $error("diag launch wrong");
  code_view_a: assert property (tx_code_out == tx_word_out[10:0]
    && tx_msg_page_out == tx_word_out[13])
    else $error("code view wrong");
  cover property (rx_page_in.valid);
  cover property (diag_start_out);
  cover property (page_sent_in ##1 tx_word_out[11]);
endmodule : angc_regs_properties

bind angc_regs angc_regs_properties #(.FD_FROM_STRAP(FD_FROM_STRAP)) i_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .mgmt_req_in(mgmt_req_in),
  .mgmt_rdata_out(mgmt_rdata_out), .mgmt_hit_out(mgmt_hit_out),
  .fd_strap_pin_in(fd_strap_pin_in), .tx_ack_in(tx_ack_in),
  .page_sent_in(page_sent_in), .rx_page_in(rx_page_in),
  .link_up_in(link_up_in), .tx_word_out(tx_word_out),
  .tx_msg_page_out(tx_msg_page_out), .tx_code_out(tx_code_out),
  .cfg_out(cfg_out), .ms_conflict_risk_out(ms_conflict_risk_out),
  .diag_start_out(diag_start_out), .page_rx_out(page_rx_out));

// ==== angc_link_partner.sv ====
// Remote link partner model that hands next pages to the bank
`timescale 1ns/100ps
module angc_link_partner (
  // Clock
  input  wire logic               clk_in,
  // Link code word toward the bank
  output logic                    page_sent_out,
  output angc_pkg::angc_page_type page_out
);
  logic tog;
  initial begin
    page_sent_out = 1'b0;
    page_out = '0;
    tog = 1'b1;
  end
  // One-cycle page; afterwards the fields are scrambled so stale data shows
  task automatic send_page(input logic more, input logic msg,
                           input logic comply, input logic [10:0] code);
    @(negedge clk_in);
    page_out = '{valid: 1'b1, more: more, ack: 1'b1, msg: msg,
                 comply: comply, toggle: tog, code: code};
    page_sent_out = 1'b1;
    @(negedge clk_in);
    page_out = {1'b0, ~page_out[15:0]};
    page_sent_out = 1'b0;
    tog = ~tog;
  endtask : send_page
endmodule : angc_link_partner

// ==== test_angc_regs.sv ====
// Self-checking bench for the next-page and gigabit config bank
`timescale 1ns/100ps
module test_angc_regs;
  // ********
  // Signals
  // ********
  logic                        clk_in;
  logic                        rst_b_in;
  logic                        fd_strap_pin_in;
  logic                        tx_ack_in;
  logic                        link_up_in;
  logic                        page_sent_in;
  logic                        mgmt_hit_out;
  logic                        tx_msg_page_out;
  logic                        ms_conflict_risk_out;
  logic                        diag_start_out;
  logic                        page_rx_out;
  logic                        seen;
  logic [10:0]                 tx_code_out;
  logic [15:0]                 mgmt_rdata_out;
  logic [15:0]                 tx_word_out;
  logic [15:0]                 wlist [5];
  angc_pkg::angc_mgmt_req_type mgmt_req_in;
  angc_pkg::angc_page_type     rx_page_in;
  angc_pkg::angc_cfg_type      cfg_out;
  int                          n_errors = 0;
  int                          num_checks = 0;

  // Strap option chosen so bit 9 reset value is fixed by the strap pin
  angc_regs #(.FD_FROM_STRAP(1'b1)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .mgmt_req_in(mgmt_req_in),
    .mgmt_rdata_out(mgmt_rdata_out), .mgmt_hit_out(mgmt_hit_out),
    .fd_strap_pin_in(fd_strap_pin_in), .tx_ack_in(tx_ack_in),
    .page_sent_in(page_sent_in), .rx_page_in(rx_page_in),
    .link_up_in(link_up_in), .tx_word_out(tx_word_out),
    .tx_msg_page_out(tx_msg_page_out), .tx_code_out(tx_code_out),
    .cfg_out(cfg_out), .ms_conflict_risk_out(ms_conflict_risk_out),
    .diag_start_out(diag_start_out), .page_rx_out(page_rx_out));
  angc_link_partner i_partner (
    .clk_in(clk_in), .page_sent_out(page_sent_in), .page_out(rx_page_in));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ********
  // Tasks
  // ********
  task automatic check(input string what, input logic [15:0] seen_v,
                       input logic [15:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    mgmt_req_in = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_in);
    mgmt_req_in = '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp_v);
    @(negedge clk_in);
    mgmt_req_in = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(negedge clk_in);
    mgmt_req_in = '0;
    check("rdata", mgmt_rdata_out, exp_v);
    check("hit", {15'h0000, mgmt_hit_out}, 16'h0001);
  endtask : rd
  task automatic cfg_case(input logic [15:0] w);
    wr(angc_pkg::ANGC_OFS_GIG_CFG, w);
    check("cfg", {7'h00, cfg_out},
          {7'h00, w[15:12], w[12] & w[11], w[10:7]});
    check("risk", {15'h0000, ms_conflict_risk_out},
          {15'h0000, w[12]});
    rd(angc_pkg::ANGC_OFS_GIG_CFG, w & 16'hff80);
  endtask : cfg_case
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // ********
  // Tests
  // ********
  initial begin
    rst_b_in = 1'b0;
    fd_strap_pin_in = 1'b0;
    tx_ack_in = 1'b0;
    link_up_in = 1'b0;
    mgmt_req_in = '0;
    wlist = '{16'hffff, 16'h1800, 16'h0800, 16'h0400, 16'h0380};
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (10) @(negedge clk_in);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h2001);
    rd(5'h09, 16'h0100);
    rd(5'h1f, 16'h0000);
    wr(5'h08, 16'h1234);
    rd(5'h08, 16'h2001);
    wr(5'h07, 16'hffff);
    rd(5'h07, 16'hb7ff);
    i_partner.send_page(1'b1, 1'b0, 1'b1, 11'h155);
    rd(5'h08, 16'hd955);
    check("flag", {15'h0000, page_rx_out}, 16'h0001);
    tx_ack_in = 1'b1;
    rd(5'h07, 16'hffff);
    rd(5'h06, 16'h0062);
    rd(5'h06, 16'h0060);
    i_partner.send_page(1'b0, 1'b1, 1'b0, 11'h001);
    rd(5'h08, 16'h6001);
    rd(5'h07, 16'hf7ff);
    wr(5'h07, 16'h1abc);
    rd(5'h07, 16'h52bc);
    check("txword", tx_word_out, 16'h52bc);
    check("txcode", {5'h00, tx_code_out}, 16'h02bc);
    check("msgpage", {15'h0000, tx_msg_page_out}, 16'h0000);
    foreach (wlist[k]) cfg_case(wlist[k]);
    for (int i = 0; i < 8; i++) cfg_case({3'(i), 13'h0000});
    for (int i = 0; i < 2; i++) begin
      wr(5'h09, {8'h00, 1'(i), 7'h00});
      link_up_in = 1'b1;
      @(negedge clk_in);
      link_up_in = 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(negedge clk_in);
        seen = seen | diag_start_out;
      end
      check("diag", {15'h0000, seen}, {15'h0000, 1'(i)});
    end
    // Reset again mid-run with the strap high: bit 9 follows the pin
    rst_b_in = 1'b0;
    fd_strap_pin_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (10) @(negedge clk_in);
    rd(5'h07, 16'h6001);
    rd(5'h09, 16'h0300);
    final_report();
  end
  // Whole run is about 150 cycles; this margin only catches a hang
  initial begin
    repeat (3000) @(posedge clk_in);
    n_errors++;
    final_report();
  end
endmodule : test_angc_regs
